// ---- rtl/wheel_cfg.svh ----
// register map, field positions, reset values and timing counts of the tooth generator
`ifndef WHEEL_CFG_SVH
`define WHEEL_CFG_SVH

// ==========================================================
// timing
`define CLK_HZ        40000000
// a half tooth of f hertz lasts CLK_HZ/(2*f) cycles
`define HALF_DIV      (`CLK_HZ / 2)
// speed mode: half tooth when sum(|v|*z) reaches radius*K
// K = (CLK_HZ/2) * 2 * pi * 3.6 / 100, v in 0.1 km/h, r in mm
`define SPEED_K       40'd4523893

// ==========================================================
// address decode, 8-bit byte address
`define BLK_CHAN      2'h0
`define BLK_DEFECT    2'h1
`define BLK_MISC      2'h2
`define OFS_CTRL      2'h0
`define OFS_FREQ      2'h1
`define OFS_SPEED     2'h2
`define OFS_RADIUS    2'h3
`define ADDR_SYNC_SEL 8'h80
`define ADDR_AUX4     8'h84
`define ADDR_AUX5     8'h88
`define ADDR_STAT_HI  4'h9

// ==========================================================
// channel control fields
`define CTRL_EN       0
`define CTRL_FMODE    1
`define CTRL_GATE     2
`define CTRL_DIRCAP   3
`define CTRL_PASSIVE  4
`define CTRL_FLEVEL   5
`define CTRL_TEETH_LO 8
`define CTRL_RST      32'h00003000
`define RADIUS_RST    32'h0000012C

// ==========================================================
// auxiliary output fields
`define AUX_EN        0
`define AUX_CFG_LO    1
`define AUX_REFEXT    3
`define AUX_VAL_LO    16
`define AUX_THRESH    16'sh0CCD

`endif

// ---- rtl/wheel_pkg.sv ----
// types shared by the tooth generator modules
package wheel_pkg;

  // ==========================================================
  // channel run states
  typedef enum logic [1:0] {
    ST_OFF = 2'b01,
    ST_RUN = 2'b10
  } run_state_e;

  // auxiliary output configurations
  typedef enum logic [1:0] {
    AUX_ANALOG     = 2'h0,
    AUX_OPEN_DRAIN = 2'h1,
    AUX_PULLUP     = 2'h2
  } aux_cfg_e;

  // ==========================================================
  // settings of one sensor channel
  typedef struct packed {
    logic               enable;
    logic               freq_mode;
    logic               fault_pattern_gate;
    logic               dir_capable;
    logic               passive_sine_type;
    logic               fault_level;
    logic [7:0]         tooth_count;
    logic signed [15:0] freq;
    logic signed [15:0] speed;
    logic [15:0]        radius;
  } chan_cfg_s;

  // visible state of one sensor channel
  typedef struct packed {
    logic [6:0] tooth;
    logic       half;
    logic       backward;
    logic       running;
  } chan_stat_s;

  // magnitude of a signed 16-bit setting
  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    abs16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : abs16

endpackage : wheel_pkg

// ---- rtl/tooth_channel.sv ----
// one sensor channel: tooth sequencer with fault substitution
`timescale 1ns/1ps
`include "wheel_cfg.svh"
module tooth_channel
  import wheel_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // settings
  input  wire chan_cfg_s  cfg_i,
  input  wire logic [127:0] defect_i,
  // results
  output logic            sig_o,
  output logic            oe_o,
  output chan_stat_s      stat_o
);

  run_state_e  state;       // run state
  logic        en_q;        // enable one cycle ago
  logic [39:0] acc;         // phase accumulator
  logic [39:0] inc_q;       // step held since last pole change
  logic [39:0] limit_q;     // threshold held since last pole change
  logic        back_q;      // direction held since last pole change
  logic [6:0]  tooth;       // current tooth index
  logic        half;        // 0 first half of tooth, 1 second

  // ==========================================================
  // decoding of the live settings
  wire logic        start     = cfg_i.enable & ~en_q;
  wire logic [7:0]  teeth     = (cfg_i.tooth_count == 8'h00) ? 8'h01 : cfg_i.tooth_count;
  wire logic [6:0]  last      = 7'(teeth - 8'h01);
  wire logic [39:0] live_inc  = cfg_i.freq_mode ? 40'(abs16(cfg_i.freq)) :
                                40'(abs16(cfg_i.speed)) * 40'(teeth); // [R10] [R11] [R18]
  wire logic [39:0] live_lim  = cfg_i.freq_mode ? 40'(`HALF_DIV) :
                                40'(cfg_i.radius) * `SPEED_K; // [R18]
  wire logic        live_back = cfg_i.dir_capable &
                                (cfg_i.freq_mode ? cfg_i.freq[15] : cfg_i.speed[15]); // [R12] [R13]
  // passive sine takes new settings at once, others at pole change
  wire logic [39:0] use_inc   = cfg_i.passive_sine_type ? live_inc  : inc_q;   // [R19]
  wire logic [39:0] use_lim   = cfg_i.passive_sine_type ? live_lim  : limit_q; // [R19]
  wire logic        use_back  = cfg_i.passive_sine_type ? live_back : back_q;
  wire logic [39:0] sum       = acc + use_inc; // zero step freezes the index [R22]
  wire logic        pole      = (use_lim != 40'h0) && (sum >= use_lim);
  wire logic [6:0]  tooth_fwd = (tooth >= last) ? 7'h00 : 7'(tooth + 7'h01); // [R21]
  wire logic [6:0]  tooth_bwd = (tooth == 7'h00 || tooth > last) ? last : 7'(tooth - 7'h01);
  wire logic [6:0]  next_tooth = (pole & half) ? (use_back ? tooth_bwd : tooth_fwd) : tooth;
  // fault level replaces the whole tooth while the gate is on [R6] [R7] [R20]
  wire logic        fault     = cfg_i.fault_pattern_gate & defect_i[tooth];
  wire logic        next_sig  = fault ? cfg_i.fault_level : ~half;

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state   <= ST_OFF;
      en_q    <= 1'b0;
      acc     <= 40'h0;
      inc_q   <= 40'h0;
      limit_q <= 40'h0;
      back_q  <= 1'b0;
      tooth   <= 7'h00;
      half    <= 1'b0;
    end else begin
      en_q <= cfg_i.enable;
      case (state)
        ST_OFF: begin
          if (start) begin // restart at tooth 0 [R9]
            state   <= ST_RUN;
            acc     <= 40'h0;
            tooth   <= 7'h00;
            half    <= 1'b0;
            inc_q   <= live_inc;
            limit_q <= live_lim;
            back_q  <= live_back;
          end
        end
        ST_RUN: begin
          if (!cfg_i.enable) begin
            state <= ST_OFF;
          end else if (use_lim != 40'h0) begin
            acc   <= pole ? sum - use_lim : sum;
            tooth <= next_tooth;
            half  <= half ^ pole;
            if (pole) begin // settings accepted at pole change [R19]
              inc_q   <= live_inc;
              limit_q <= live_lim;
              back_q  <= live_back;
            end
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // output level and driver enable, released while disabled [R8]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sig_o <= 1'b0;
      oe_o  <= 1'b0;
    end else begin
      sig_o <= next_sig;
      oe_o  <= (state == ST_RUN) & cfg_i.enable;
    end
  end

  assign stat_o = '{tooth: tooth, half: half, backward: use_back, running: state == ST_RUN};

endmodule : tooth_channel

// ---- rtl/wheel_tooth_sequence_generator.sv ----
// four-channel wheel tooth sequence generator with two auxiliary outputs
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "wheel_cfg.svh"

// Function
// R1 - four independent channel generators
// R2 - sensors on 0-3, auxiliaries on 4-5
// R3 - channels 0-3 fixed to wheel positions
// R4 - sync marker high during selected tooth 0
// R5 - teeth 0..count-1, each maskable defective
// R6 - defective tooth outputs fault level whole
// R7 - substitution only while gate is on
// R8 - disabled channel output high-impedance
// R9 - enable restarts at tooth 0, drives output
// R10 - mode picks speed or frequency source
// R11 - frequency ignored in speed mode
// R12 - negative frequency runs backward if capable
// R13 - no direction sensing uses magnitude only
// R14 - auxiliary enable, disabled is high-impedance
// R15 - auxiliary analog, open-drain or pull-up
// R16 - binary low below 0.1, else high
// R17 - analog output value times reference
// R18 - speed mode frequency from speed, teeth, radius
// R19 - settings apply at pole change, sine immediately
// R20 - fault gate changes apply immediately
// R21 - forward increments, backward decrements, both wrap
// R22 - zero frequency freezes index
module wheel_tooth_sequence_generator
  import wheel_pkg::*;
(
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  // register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  // sensor channels 0..3
  output logic      [3:0]  SENS_O,
  output logic      [3:0]  SENS_OE_O,
  output logic             SYNC_O,
  // auxiliary channels 4 and 5
  output logic      [1:0]  AUX_OE_O,
  output logic      [1:0]  AUX_PULLUP_O,
  output logic      [1:0]  AUX_REF_EXT_O,
  output logic      [31:0] AUX_DAC_O
);

  // ==========================================================
  // wheel positions of the sensor channels, never remapped [R3]
  localparam logic [1:0] FRONT_LEFT  = 2'h0;
  localparam logic [1:0] FRONT_RIGHT = 2'h1;
  localparam logic [1:0] REAR_LEFT   = 2'h2;
  localparam logic [1:0] REAR_RIGHT  = 2'h3;

  // ==========================================================
  // register storage
  logic [31:0] ctrl   [0:3];  // channel control words
  logic [31:0] freq   [0:3];  // commanded frequency, signed hertz
  logic [31:0] speed  [0:3];  // wheel speed, signed 0.1 km/h
  logic [31:0] radius [0:3];  // wheel radius in mm
  logic [31:0] defect [0:15]; // defective tooth map, four words a channel [R5]
  logic [1:0]  sync_sel;      // channel followed by the sync marker
  logic [31:0] aux    [0:1];  // auxiliary output words

  // channel results
  chan_cfg_s   cfg   [0:3];   // settings handed to each channel
  chan_stat_s  stat  [0:3];   // state reported by each channel
  logic [3:0]  ch_sig;        // channel levels
  logic [3:0]  ch_oe;         // channel driver enables

  // ==========================================================
  // address decode
  wire logic [1:0] a_blk   = ADDR_I[7:6];
  wire logic [1:0] a_ch    = ADDR_I[5:4];
  wire logic [1:0] a_wd    = ADDR_I[3:2];
  wire logic       a_align = (ADDR_I[1:0] == 2'h0);
  wire logic       hit_ch  = a_align & (a_blk == `BLK_CHAN);
  wire logic       hit_def = a_align & (a_blk == `BLK_DEFECT);
  wire logic       hit_sy  = (ADDR_I == `ADDR_SYNC_SEL);
  wire logic       hit_a4  = (ADDR_I == `ADDR_AUX4);
  wire logic       hit_a5  = (ADDR_I == `ADDR_AUX5);
  wire logic       hit_st  = a_align & (ADDR_I[7:4] == `ADDR_STAT_HI);
  wire logic [3:0] def_idx = {a_ch, a_wd};

  // ==========================================================
  // register writes
  // each channel keeps its own settings, so one write never
  // disturbs another channel's sequence [R1]
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < 4; i++) begin
        ctrl[i]   <= `CTRL_RST;
        freq[i]   <= 32'h0;
        speed[i]  <= 32'h0;
        radius[i] <= `RADIUS_RST;
      end
    end else if (WR_I && hit_ch) begin
      case (a_wd)
        `OFS_CTRL:   ctrl[a_ch]   <= WDATA_I;
        `OFS_FREQ:   freq[a_ch]   <= WDATA_I;
        `OFS_SPEED:  speed[a_ch]  <= WDATA_I;
        `OFS_RADIUS: radius[a_ch] <= WDATA_I;
        default:     ctrl[a_ch]   <= ctrl[a_ch];
      endcase
    end
  end

  // defective tooth map, one bit per tooth index
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < 16; i++) begin
        defect[i] <= 32'h0;
      end
    end else if (WR_I && hit_def) begin
      defect[def_idx] <= WDATA_I; // [R5]
    end
  end

  // sync selection and auxiliary words
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      sync_sel <= 2'h0;
      aux[0]   <= 32'h0;
      aux[1]   <= 32'h0;
    end else if (WR_I) begin
      if (hit_sy) begin
        sync_sel <= WDATA_I[1:0];
      end
      if (hit_a4) begin
        aux[0] <= WDATA_I;
      end
      if (hit_a5) begin
        aux[1] <= WDATA_I;
      end
    end
  end

  // ==========================================================
  // sensor channels 0..3, one generator each [R1] [R2]
  for (genvar c = 0; c < 4; c++) begin : g_chan
    // unpack the control word into the channel settings
    assign cfg[c] = '{
      enable:             ctrl[c][`CTRL_EN],
      freq_mode:          ctrl[c][`CTRL_FMODE],
      fault_pattern_gate: ctrl[c][`CTRL_GATE],
      dir_capable:        ctrl[c][`CTRL_DIRCAP],
      passive_sine_type:  ctrl[c][`CTRL_PASSIVE],
      fault_level:        ctrl[c][`CTRL_FLEVEL],
      tooth_count:        ctrl[c][`CTRL_TEETH_LO +: 8],
      freq:               freq[c][15:0],
      speed:              speed[c][15:0],
      radius:             radius[c][15:0]
    };

    tooth_channel u_chan (
      .clk_i    (REF_CLK_I),
      .rst_i    (RST_I),
      .cfg_i    (cfg[c]),
      .defect_i ({defect[4*c+3], defect[4*c+2], defect[4*c+1], defect[4*c]}),
      .sig_o    (ch_sig[c]),
      .oe_o     (ch_oe[c]),
      .stat_o   (stat[c])
    );
  end

  // ==========================================================
  // sync marker source
  // the marker leads the sensor output by one cycle, which keeps the
  // port a plain flip-flop at the cost of a fixed skew
  wire chan_stat_s sync_stat = stat[sync_sel];
  wire logic       next_sync = sync_stat.running & (sync_stat.tooth == 7'h00); // [R4]

  // ==========================================================
  // auxiliary output decode, one slice per channel 4 and 5
  logic       aux_en   [0:1];  // output enable bit
  aux_cfg_e   aux_mode [0:1];  // analog or binary flavour
  logic       aux_high [0:1];  // control value at or above 0.1
  logic [1:0] next_aoe;        // next driver enables
  logic [1:0] next_apu;        // next pull-up source enables

  for (genvar a = 0; a < 2; a++) begin : g_aux
    assign aux_en[a]   = aux[a][`AUX_EN]; // [R14]
    assign aux_mode[a] = aux_cfg_e'(aux[a][`AUX_CFG_LO +: 2]); // [R15]
    // values are signed 1.15, so 0.1 is the first code above 3276.8
    assign aux_high[a] = $signed(aux[a][`AUX_VAL_LO +: 16]) >= `AUX_THRESH; // [R16]
    // analog drives whenever enabled; binary pins only pull low,
    // the high level comes from the pull-up or from outside
    assign next_aoe[a] = aux_en[a] &
                         ((aux_mode[a] == AUX_ANALOG) ? 1'b1 : ~aux_high[a]); // [R14] [R16]
    assign next_apu[a] = aux_en[a] & (aux_mode[a] == AUX_PULLUP); // [R15]
  end

  // ==========================================================
  // read data, answered the cycle after the strobe
  logic [31:0] rd_mux;  // selected read word
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ch) begin
      case (a_wd)
        `OFS_CTRL:   rd_mux = ctrl[a_ch];
        `OFS_FREQ:   rd_mux = freq[a_ch];
        `OFS_SPEED:  rd_mux = speed[a_ch];
        `OFS_RADIUS: rd_mux = radius[a_ch];
        default:     rd_mux = 32'h0;
      endcase
    end else if (hit_def) begin
      rd_mux = defect[def_idx];
    end else if (hit_sy) begin
      rd_mux = {30'h0, sync_sel};
    end else if (hit_a4) begin
      rd_mux = aux[0];
    end else if (hit_a5) begin
      rd_mux = aux[1];
    end else if (hit_st) begin
      // live channel state: tooth, half, direction, running
      rd_mux = {21'h0, stat[a_wd].running, stat[a_wd].backward,
                stat[a_wd].half, 1'b0, stat[a_wd].tooth};
    end
  end

  // read port; unmapped reads return zero
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      RDATA_O <= 32'h0;
    end else begin
      RDATA_O <= RD_I ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // output flip-flops
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      SENS_O        <= 4'h0;
      SENS_OE_O     <= 4'h0;
      SYNC_O        <= 1'b0;
      AUX_OE_O      <= 2'h0;
      AUX_PULLUP_O  <= 2'h0;
      AUX_REF_EXT_O <= 2'h0;
      AUX_DAC_O     <= 32'h0;
    end else begin
      SENS_O        <= ch_sig;
      SENS_OE_O     <= ch_oe; // [R8] [R9]
      SYNC_O        <= next_sync; // [R4]
      AUX_OE_O      <= next_aoe;
      AUX_PULLUP_O  <= next_apu;
      // reference choice and signed control code for the converter [R17]
      AUX_REF_EXT_O <= {aux[1][`AUX_REFEXT], aux[0][`AUX_REFEXT]};
      AUX_DAC_O     <= {aux[1][`AUX_VAL_LO +: 16], aux[0][`AUX_VAL_LO +: 16]};
    end
  end

endmodule : wheel_tooth_sequence_generator

// ---- sim/wheel_checker_asserts.sv ----
// port assertions for the wheel tooth sequence generator
`timescale 1ns/1ps
module wheel_checker (
  // clock, reset and register port
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [31:0] RDATA_O,
  // sensor and auxiliary outputs
  input wire logic [3:0]  SENS_O,
  input wire logic [3:0]  SENS_OE_O,
  input wire logic        SYNC_O,
  input wire logic [1:0]  AUX_OE_O,
  input wire logic [1:0]  AUX_PULLUP_O,
  input wire logic [1:0]  AUX_REF_EXT_O,
  input wire logic [31:0] AUX_DAC_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // ==========================================================
  // helper logic
  logic        ctl1;  // control write to channel 1
  logic        aux4;  // write to auxiliary output 4
  logic [3:0]  aux_w; // aux writes of the last four cycles
  logic [15:0] v4;    // last code written to output 4
  logic [1:0]  sel;   // channel followed by the sync marker
  assign ctl1 = WR_I && ADDR_I == 8'h10;
  assign aux4 = WR_I && ADDR_I == 8'h84;
  // history kept so latency of the aux path may be up to three cycles
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      aux_w <= 4'h0;
      v4 <= 16'h0;
      sel <= 2'h0;
    end else begin
      aux_w <= {aux_w[2:0], WR_I && ADDR_I[7:4] == 4'h8 && ADDR_I[3:0] != 4'h0};
      if (aux4) v4 <= WDATA_I[31:16];
      if (WR_I && ADDR_I == 8'h80) sel <= WDATA_I[1:0];
    end
  end
  // ==========================================================
  // sensor channel
  property p_oe_off;
    ctl1 && !WDATA_I[0] |-> ##[1:5] !SENS_OE_O[1];
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("channel still driven");
  // restart shows the first half of tooth 0
  property p_oe_on;
    ctl1 && WDATA_I[0] && !WDATA_I[2] && !SENS_OE_O[1] |-> ##[2:6] SENS_OE_O[1] && SENS_O[1];
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("channel not restarted");
  property p_sync;
    $rose(SYNC_O) |-> ##[0:2] SENS_O[sel];
  endproperty
  a_sync: assert property (p_sync) else $error("sync off tooth start");
  // ==========================================================
  // auxiliary outputs
  property p_quiet;
    $changed(AUX_OE_O) |-> |aux_w;
  endproperty
  a_quiet: assert property (p_quiet) else $error("aux moved unasked");
  property p_off;
    aux4 && !WDATA_I[0] |-> ##[1:3] !AUX_OE_O[0] && !AUX_PULLUP_O[0];
  endproperty
  a_off: assert property (p_off) else $error("aux not released");
  property p_pullup;
    aux4 && WDATA_I[2:0] == 3'h5 |-> ##[1:3] AUX_PULLUP_O[0];
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up missing");
  property p_od_low;
    aux4 && WDATA_I[2:0] == 3'h3 && $signed(WDATA_I[31:16]) < 16'sh0CCD |-> ##[1:3] AUX_OE_O[0];
  endproperty
  a_od_low: assert property (p_od_low) else $error("binary not low");
  property p_od_high;
    aux4 && WDATA_I[2:0] == 3'h3 && $signed(WDATA_I[31:16]) >= 16'sh0CCD |-> ##[1:3] !AUX_OE_O[0];
  endproperty
  a_od_high: assert property (p_od_high) else $error("binary not high");
  property p_dac;
    aux4 && WDATA_I[2:1] == 2'h0 |-> ##[1:3] AUX_DAC_O[15:0] == v4;
  endproperty
  a_dac: assert property (p_dac) else $error("analog code wrong");
endmodule : wheel_checker

bind wheel_tooth_sequence_generator wheel_checker u_chk (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SENS_O(SENS_O), .SENS_OE_O(SENS_OE_O),
  .SYNC_O(SYNC_O), .AUX_OE_O(AUX_OE_O), .AUX_PULLUP_O(AUX_PULLUP_O),
  .AUX_REF_EXT_O(AUX_REF_EXT_O), .AUX_DAC_O(AUX_DAC_O));

// ---- sim/ecu_model.sv ----
// control unit front end: resolves the sensor wires and counts pole changes
`timescale 1ns/1ps
module ecu_model (
  // clock
  input  wire logic        clk_i,
  // sensor wires as driven
  input  wire logic [3:0]  sens_i,
  input  wire logic [3:0]  oe_i,
  // resolved level and pole counts
  output logic [3:0]       wire_o,
  output logic [3:0][15:0] poles_o
);
  // ==========================================================
  // wire resolution
  logic [3:0] last = 4'h0; // last driven level
  // an undriven wire has no pull, so it shows the inverse of its last level
  assign wire_o = (sens_i & oe_i) | (~last & ~oe_i);
  initial poles_o = '0;
  // count each driven level change as one pole change
  always @(posedge clk_i) begin
    for (int n = 0; n < 4; n++) begin
      if (oe_i[n] && sens_i[n] !== last[n]) poles_o[n] <= poles_o[n] + 16'h1;
      if (oe_i[n]) last[n] <= sens_i[n];
    end
  end
endmodule : ecu_model

// ---- sim/wheel_tooth_sequence_generator_tb_top.sv ----
// self-checking bench for the wheel tooth sequence generator
`timescale 1ns/1ps
module wheel_tooth_sequence_generator_tb_top;
  // ==========================================================
  // signals
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, rd_d = 1'b0, sync;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, dac, rd_last, s;
  logic [3:0]  sens, oe, lvl;
  logic [1:0]  aoe, apu, aext;
  logic [3:0][15:0] poles;
  logic [15:0] p, v;
  logic [32:0] exp_q [$]; // bit 32 set: answer is compared
  logic signed [15:0] od [3] = '{16'sh0CCC, 16'sh0CCD, 16'sh8000};
  int n_errors = 0, tests_run = 0, cyc = 0;
  // ==========================================================
  // design and far side
  wheel_tooth_sequence_generator u_dut (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .SENS_O(sens),
    .SENS_OE_O(oe), .SYNC_O(sync), .AUX_OE_O(aoe), .AUX_PULLUP_O(apu),
    .AUX_REF_EXT_O(aext), .AUX_DAC_O(dac));
  ecu_model u_ecu (.clk_i(clk), .sens_i(sens), .oe_i(oe), .wire_o(lvl), .poles_o(poles));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // one-cycle write strobe, then a quiet cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wr
  // read strobe; the answer lands in rd_last before return
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    addr <= a;
    rd_s <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_s <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : rd
  // let register effects reach the pins
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle
  // poll channel 1 until its tooth moves, bounded
  task automatic next_tooth(output logic [6:0] t);
    logic [6:0] t0;
    rd(8'h94, 33'h0);
    t0 = rd_last[6:0];
    t = t0;
    for (int i = 0; i < 100 && t == t0; i++) begin
      rd(8'h94, 33'h0);
      t = rd_last[6:0];
    end
  endtask : next_tooth
  // two tooth moves: the second must be one step of the given size
  task automatic dir_chk(input logic [6:0] step);
    logic [6:0] a, b;
    next_tooth(a);
    next_tooth(b);
    chk(b, (a + step) & 7'h3);
  endtask : dir_chk
  // ==========================================================
  // read monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_d <= rd_s;
    if (rd_d) begin
      rd_last = rdata;
      if (exp_q[0][32]) chk(rdata, exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hC44D24DD));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 33'h1_0000_3000);
    rd(8'h0C, 33'h1_0000_012C);
    rd(8'hFC, 33'h1_0000_0000);
    // channel 1: speed mode, four teeth, shortest poles, sync on it
    wr(8'h80, 32'h0000_0001);
    wr(8'h1C, 32'h0000_0001);
    wr(8'h18, 32'h0000_7FFF);
    wr(8'h10, 32'h0000_0401);
    settle();
    rd(8'h94, 33'h1_0000_0400);
    chk(oe, 4'b0010);
    for (int k = 0; k < 3; k++) dir_chk(7'h1);
    // negative speed: backward only with direction sensing
    wr(8'h18, 32'hFFFF_8001);
    wr(8'h10, 32'h0000_0409);
    dir_chk(7'h3);
    dir_chk(7'h3);
    wr(8'h10, 32'h0000_0401);
    dir_chk(7'h1);
    // a frequency in speed mode must not move a stopped wheel
    wr(8'h14, 32'h0000_09C4);
    wr(8'h18, 32'h0000_0000);
    repeat (100) @(posedge clk);
    rd(8'h94, 33'h0);
    s = rd_last;
    p = poles[1];
    repeat (200) @(posedge clk);
    rd(8'h94, {1'b1, s});
    chk(poles[1], p);
    // mark the frozen tooth defective, flip gate and level
    wr(8'h50, 32'h0000_0001 << s[4:0]);
    wr(8'h10, 32'h0000_0425);
    settle();
    chk(sens[1], 1'b1);
    wr(8'h10, 32'h0000_0405);
    settle();
    chk(sens[1], 1'b0);
    wr(8'h10, 32'h0000_0401);
    settle();
    chk(sens[1], !s[8]);
    // disable, then restart at tooth 0
    wr(8'h10, 32'h0000_0400);
    settle();
    chk(oe[1], 1'b0);
    // released wire floats to the inverse of its last driven level
    chk(lvl[1], s[8]);
    wr(8'h18, 32'h0000_7FFF);
    wr(8'h10, 32'h0000_0401);
    settle();
    rd(8'h94, 33'h1_0000_0400);
    chk(sync, 1'b1);
    rd(8'h90, 33'h1_0000_0000);
    // marker moved to idle channel 0 must drop
    wr(8'h80, 32'h0000_0000);
    settle();
    chk(sync, 1'b0);
    // auxiliary outputs 4 and 5
    for (int i = 0; i < 2; i++) begin
      v = 16'($urandom);
      wr(8'h84 + 8'(4 * i), {v, 16'h0009});
      settle();
      chk(dac[16*i +: 16], v);
      chk({aoe[i], apu[i], aext[i]}, 3'b101);
      for (int j = 0; j < 3; j++) begin
        wr(8'h84 + 8'(4 * i), {od[j], 16'h0003});
        settle();
        chk(aoe[i], od[j] < 16'sh0CCD);
      end
      wr(8'h84 + 8'(4 * i), 32'h0000_0005);
      settle();
      chk({aoe[i], apu[i]}, 2'b11);
      wr(8'h84 + 8'(4 * i), 32'h0000_0004);
      settle();
      chk({aoe[i], apu[i]}, 2'b00);
    end
    final_report();
  end
endmodule : wheel_tooth_sequence_generator_tb_top
